//--- hdl/output_post_divider.v
// post-divider stage of one synthesizer output: clock divider or frame pulse
//
// Functional notes
// - shape field 23:20 equal to 1111 selects frame pulse output.
// - other shape values give 50% clock, ratio is whole 24-bit value.
// - frame pulses spaced by period field 15:0 related-clock periods.
// - selector 17:16: 01 B, 10 C, 11 D, 00 reserved.
// - each frame pulse lasts exactly one related-clock period.
// - bit 18 zero gives non-inverted pulse, one gives inverted pulse.
// - bit 19 zero centres boundary in pulse, one puts boundary at edge.
// - normal mode divides oscillator clock by the programmed value, except 1 which divides by 2 and 0 which holds the output low.
`timescale 1ns/10ps
`default_nettype none
`include "post_div_defs.vh"

module output_post_divider #(
  parameter integer CFG_W = `PD_CFG_W
) (
  // clock and reset
  input  wire        REF_CLK,
  input  wire        SYS_RST,
  // axi4-lite write address
  input  wire [31:0] AWADDR,
  input  wire        AWVALID,
  output wire        AWREADY,
  // axi4-lite write data
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output wire        WREADY,
  // axi4-lite write response
  output wire [1:0]  BRESP,
  output wire        BVALID,
  input  wire        BREADY,
  // axi4-lite read address
  input  wire [31:0] ARADDR,
  input  wire        ARVALID,
  output wire        ARREADY,
  // axi4-lite read data
  output wire [31:0] RDATA,
  output wire [1:0]  RRESP,
  output wire        RVALID,
  input  wire        RREADY,
  // related clocks from sibling post-dividers
  input  wire        REL_CLK_B,
  input  wire        REL_CLK_C,
  input  wire        REL_CLK_D,
  // divided clock or frame pulse
  output wire        CLK_OUT
);

  // ****************************************
  // helpers
  // ****************************************
  function is_frame;
    input [CFG_W-1:0] cfg;
    begin
      is_frame = (cfg[`PD_SHAPE_HI:`PD_SHAPE_LO] == `PD_SHAPE_FRAME);
    end
  endfunction

  function [CFG_W-1:0] merge_bytes;
    input [CFG_W-1:0] old;
    input [31:0]      data;
    input [3:0]       strb;
    integer i;
    begin
      merge_bytes = old;
      for (i = 0; i < CFG_W / 8; i = i + 1) begin
        if (strb[i]) begin
          merge_bytes[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************
  // bus slave state
  // ****************************************
  reg                    awready_r;
  reg                    wready_r;
  reg                    aw_got_r;
  reg                    w_got_r;
  reg [`PD_ADDR_W-1:0]   waddr_r;
  reg [31:0]             wdata_r;
  reg [3:0]              wstrb_r;
  reg                    bvalid_r;
  reg [1:0]              bresp_r;
  reg                    arready_r;
  reg                    rvalid_r;
  reg [31:0]             rdata_r;
  reg [1:0]              rresp_r;

  // ****************************************
  // configuration and output state
  // ****************************************
  reg [CFG_W-1:0]        cfg_r;
  reg [CFG_W-1:0]        act_r;
  reg                    pend_r;
  reg                    rel_prev_r;
  reg [15:0]             fcnt_r;
  reg                    pulse_r;
  reg                    out_r;

  wire                   wr_fire;
  wire                   wr_cfg;
  wire                   act_frame;
  wire [1:0]             act_sel;
  wire [15:0]            act_period;
  wire                   sel_ok;
  wire                   rel_now;
  wire                   rel_rise;
  wire                   rel_fall;
  wire                   last_slot;
  wire                   boundary;
  wire                   div_tc;
  wire                   div_level;
  wire                   running;
  wire                   load;
  wire                   frame_end;
  wire [3:0]             rel_all;
  wire                   rel_next;

  assign wr_fire    = aw_got_r && w_got_r && !bvalid_r;
  assign wr_cfg     = wr_fire && (waddr_r == `PD_CFG_ADDR);

  assign act_frame  = is_frame(act_r);
  assign act_sel    = act_r[`PD_SEL_HI:`PD_SEL_LO];
  assign act_period = act_r[`PD_PERIOD_HI:`PD_PERIOD_LO];
  assign sel_ok     = (act_sel != `PD_SEL_RSVD);

  // ****************************************
  // related clock choice and edges
  // ****************************************
  // index 0 is the reserved code and reads as a quiet line
  assign rel_all   = {REL_CLK_D, REL_CLK_C, REL_CLK_B, 1'b0};
  assign rel_now   = rel_all[act_sel];
  // pending selector's clock, so a selector change at load makes no false edge
  assign rel_next  = rel_all[cfg_r[`PD_SEL_HI:`PD_SEL_LO]];

  // own-divider loopback is not detectable here; software must avoid it
  assign rel_rise  = rel_now && !rel_prev_r;
  assign rel_fall  = !rel_now && rel_prev_r;
  assign last_slot = (fcnt_r == act_period - 16'h0001);
  assign boundary  = rel_rise && last_slot;

  // ****************************************
  // normal-mode divider
  // ****************************************
  ratio_divider #(
    .WIDTH   (CFG_W)
  ) u_div (
    .clk     (REF_CLK),
    .rst     (SYS_RST),
    .restart (load || act_frame),
    .ratio   (act_r),
    .tc      (div_tc),
    .level   (div_level)
  );

  // a stopped output has no terminal count, so a new setting loads at once
  assign running = act_frame ? (sel_ok && (act_period != 16'h0000)) : (act_r != {CFG_W{1'b0}});
  // a straddled pulse ends half a period after its boundary; swap there, not mid-pulse
  assign frame_end = act_r[`PD_TYPE_BIT] ? boundary : (rel_fall && (fcnt_r == 16'h0000));
  assign load      = pend_r && (!running || (act_frame ? frame_end : div_tc));

  // ****************************************
  // configuration shadowing
  // ****************************************
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_r  <= `PD_CFG_RESET;
      act_r  <= `PD_CFG_RESET;
      pend_r <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= merge_bytes(cfg_r, wdata_r, wstrb_r);
      end
      if (load) begin
        act_r <= cfg_r;
      end
      // a write in the load cycle keeps the update pending
      if (wr_cfg) begin
        pend_r <= 1'b1;
      end else if (load) begin
        pend_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // frame pulse generator
  // ****************************************
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rel_prev_r <= 1'b0;
      fcnt_r     <= 16'h0000;
      pulse_r    <= 1'b0;
    end else begin
      rel_prev_r <= load ? rel_next : rel_now;
      if (load || !act_frame || !running) begin
        fcnt_r  <= 16'h0000;
        pulse_r <= 1'b0;
      end else begin
        if (rel_rise) begin
          fcnt_r <= last_slot ? 16'h0000 : fcnt_r + 16'h0001;
        end
        if (act_r[`PD_TYPE_BIT]) begin
          // boundary at the leading edge: rise to rise
          if (rel_rise) begin
            pulse_r <= boundary;
          end
        end else begin
          // boundary straddled: fall before it to fall after it
          if (rel_fall) begin
            pulse_r <= last_slot;
          end
        end
      end
    end
  end

  // ****************************************
  // output selection
  // ****************************************
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_r <= 1'b0;
    end else if (act_frame) begin
      out_r <= pulse_r ^ act_r[`PD_POL_BIT];
    end else begin
      out_r <= div_level;
    end
  end

  // ****************************************
  // axi4-lite write channels
  // ****************************************
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      waddr_r   <= {`PD_ADDR_W{1'b0}};
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PD_RESP_OKAY;
    end else begin
      if (awready_r && AWVALID) begin
        aw_got_r  <= 1'b1;
        waddr_r   <= AWADDR[`PD_ADDR_W-1:0];
        awready_r <= 1'b0;
      end else begin
        awready_r <= !aw_got_r && !bvalid_r;
      end
      if (wready_r && WVALID) begin
        w_got_r  <= 1'b1;
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
        wready_r <= 1'b0;
      end else begin
        wready_r <= !w_got_r && !bvalid_r;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        // status is read-only; only the configuration word accepts writes
        bresp_r  <= (waddr_r == `PD_CFG_ADDR) ? `PD_RESP_OKAY : `PD_RESP_SLVERR;
      end else if (bvalid_r && BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read channels
  // ****************************************
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `PD_RESP_OKAY;
    end else begin
      if (arready_r && ARVALID) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rresp_r   <= `PD_RESP_OKAY;
        rdata_r   <= 32'h00000000;
        case (ARADDR[`PD_ADDR_W-1:0])
          `PD_CFG_ADDR: begin
            rdata_r[CFG_W-1:0] <= cfg_r;
          end
          `PD_STATUS_ADDR: begin
            rdata_r[`PD_ST_FRAME_BIT] <= act_frame;
            rdata_r[`PD_ST_PEND_BIT]  <= pend_r;
            rdata_r[`PD_ST_OUT_BIT]   <= out_r;
            rdata_r[`PD_ST_RUN_BIT]   <= running;
          end
          default: begin
            rresp_r <= `PD_RESP_SLVERR;
          end
        endcase
      end else begin
        if (rvalid_r && RREADY) begin
          rvalid_r <= 1'b0;
        end
        arready_r <= !rvalid_r;
      end
    end
  end

  assign AWREADY = awready_r;
  assign WREADY  = wready_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;
  assign CLK_OUT = out_r;

endmodule // output_post_divider

`default_nettype wire

//--- hdl/post_div_defs.vh
// constants for the output post-divider and frame pulse block
`ifndef POST_DIV_DEFS_VH
`define POST_DIV_DEFS_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define PD_ADDR_W          8
`define PD_CFG_ADDR        8'ha4
`define PD_STATUS_ADDR     8'hb0

// ****************************************
// configuration register fields
// ****************************************
`define PD_CFG_W           24
`define PD_CFG_RESET       24'h000000
`define PD_SHAPE_HI        23
`define PD_SHAPE_LO        20
`define PD_SHAPE_FRAME     4'hf
`define PD_TYPE_BIT        19
`define PD_POL_BIT         18
`define PD_SEL_HI          17
`define PD_SEL_LO          16
`define PD_PERIOD_HI       15
`define PD_PERIOD_LO       0
`define PD_SEL_RSVD        2'h0
`define PD_SEL_B           2'h1
`define PD_SEL_C           2'h2
`define PD_SEL_D           2'h3

// ****************************************
// status register fields
// ****************************************
`define PD_ST_FRAME_BIT    0
`define PD_ST_PEND_BIT     1
`define PD_ST_OUT_BIT      2
`define PD_ST_RUN_BIT      3

// ****************************************
// bus answers
// ****************************************
`define PD_RESP_OKAY       2'h0
`define PD_RESP_SLVERR     2'h2

`endif

//--- hdl/ratio_divider.v
// 50% duty-cycle counter divider with terminal-count strobe
`timescale 1ns/10ps
`default_nettype none

module ratio_divider #(
  parameter integer WIDTH = 24
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // control
  input  wire             restart,
  input  wire [WIDTH-1:0] ratio,
  // result
  output wire             tc,
  output wire             level
);

  reg  [WIDTH-1:0] cnt_r;
  reg  [WIDTH-1:0] cnt_nxt;
  wire [WIDTH-1:0] eff_ratio;
  wire [WIDTH-1:0] high_len;

  // ratio 1 cannot be made from registered logic; run it as 2
  assign eff_ratio = (ratio == {{(WIDTH-1){1'b0}}, 1'b1}) ? {{(WIDTH-2){1'b0}}, 2'b10} : ratio;
  // odd ratios keep the extra cycle in the high phase
  assign high_len  = eff_ratio - (eff_ratio >> 1);
  assign tc        = (eff_ratio != {WIDTH{1'b0}}) && (cnt_r == eff_ratio - {{(WIDTH-1){1'b0}}, 1'b1});
  assign level     = (eff_ratio != {WIDTH{1'b0}}) && (cnt_r < high_len);

  always @* begin
    if (restart || tc || (eff_ratio == {WIDTH{1'b0}})) begin
      cnt_nxt = {WIDTH{1'b0}};
    end else begin
      cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {WIDTH{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // ratio_divider

`default_nettype wire

//--- bench/post_div_sva.sv
// assertion checker for the output post-divider ports
`timescale 1ns/10ps
`default_nettype none
`include "post_div_defs.vh"

module post_div_sva (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // register bus
  input wire logic [31:0] AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0]  WSTRB,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // related clocks and output
  input wire logic        REL_CLK_B,
  input wire logic        REL_CLK_C,
  input wire logic        REL_CLK_D,
  input wire logic        CLK_OUT
);
  // ****
  // shadow of the last written setting
  // ****
  logic [23:0] cfg_r;
  logic [5:0]  quiet_r;
  logic        rel;
  logic        act;
  wire         wr_cfg = AWVALID && AWREADY && WVALID && WREADY && AWADDR[7:0] == `PD_CFG_ADDR;
  assign rel = (cfg_r[17:16] == 2'h1) ? REL_CLK_B : (cfg_r[17:16] == 2'h2) ? REL_CLK_C : REL_CLK_D;
  assign act = CLK_OUT ^ cfg_r[18];
  // quiet_r saturates so the frame checks start only once a pending setting surely landed
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_r <= 24'h000000;
      quiet_r <= 6'h00;
    end else if (wr_cfg && WSTRB[2:0] == 3'h7) begin
      cfg_r <= WDATA[23:0];
      quiet_r <= 6'h10;
    end else if (quiet_r != 6'h3f) begin
      quiet_r <= quiet_r + 6'h01;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_hi2;
    CLK_OUT [*2];
  endsequence
  sequence s_lo2;
    !CLK_OUT [*2];
  endsequence
  AST_B_ANSWER:
    assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID) else $error("write answer late");
  AST_B_HOLD:
    assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write answer dropped");
  AST_R_ANSWER:
    assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
  AST_R_HOLD:
    assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read answer dropped");
  AST_AR_BLOCK:
    assert property (RVALID |-> !ARREADY) else $error("read taken while answer pending");
  AST_W_BLOCK:
    assert property (BVALID |-> !AWREADY && !WREADY) else $error("write taken while answer pending");
  AST_NORM_RATIO:
    assert property (cfg_r == 24'h000004 && $rose(CLK_OUT) |-> s_hi2 ##1 s_lo2) else $error("ratio 4 shape");
  AST_FRM_IDLE:
    assert property (quiet_r == 6'h3f && cfg_r[23:20] == 4'hf && (cfg_r[17:16] == 2'h0 || cfg_r[15:0] == 16'h0)
      |-> CLK_OUT == cfg_r[18]) else $error("idle level");
  AST_FRM_EDGE:
    assert property (quiet_r == 6'h3f && cfg_r[23:20] == 4'hf && cfg_r[17:16] != 2'h0 && cfg_r[15:0] > 16'h1
      && $changed(act) |-> $past(rel, 2) == cfg_r[19]) else $error("pulse edge misaligned");
endmodule // post_div_sva
`default_nettype wire

//--- bench/rel_clk_model.sv
// sibling post-divider clocks feeding the frame pulse logic
`timescale 1ns/10ps
`default_nettype none

module rel_clk_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // related clocks
  output var logic  rel_b,
  output var logic  rel_c,
  output var logic  rel_d
);
  logic [4:0] cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cnt_r <= 5'h00;
    else
      cnt_r <= (cnt_r == 5'h17) ? 5'h00 : cnt_r + 5'h01;
  end
  // periods 6, 4 and 8 so a wrong selector shows as a wrong width
  always_comb begin
    rel_b = (cnt_r % 5'h06) < 5'h03;
    rel_c = cnt_r[1];
    rel_d = cnt_r[2];
  end
endmodule // rel_clk_model
`default_nettype wire

//--- bench/test_output_post_divider.sv
// self-checking bench for the output post-divider
`timescale 1ns/10ps
`default_nettype none
`include "post_div_defs.vh"

module test_output_post_divider;
  logic        REF_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA;
  logic [3:0]  WSTRB = 4'hf;
  logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [1:0]  BRESP, RRESP;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, REL_CLK_B, REL_CLK_C, REL_CLK_D, CLK_OUT;
  int          num_errors = 0;
  int          n_checks = 0;

  output_post_divider DUT (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .REL_CLK_B(REL_CLK_B), .REL_CLK_C(REL_CLK_C), .REL_CLK_D(REL_CLK_D),
    .CLK_OUT(CLK_OUT));
  rel_clk_model u_rel (.clk(REF_CLK), .rst(SYS_RST), .rel_b(REL_CLK_B), .rel_c(REL_CLK_C), .rel_d(REL_CLK_D));

  initial begin
    forever #20 REF_CLK = ~REF_CLK;
  end

  // ****
  // helpers
  // ****
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", s, e, g);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge REF_CLK);
    n++;
    if (n > 400) begin
      chk("wait", 1, 0);
      tally_and_finish();
    end
  endtask

  task automatic do_reset;
    SYS_RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    logic aw = 1'b1;
    logic w = 1'b1;
    @(posedge REF_CLK);
    AWADDR <= {24'h0, a};
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (aw || w) begin
      tick(n);
      if (aw && AWREADY === 1'b1) begin
        aw = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY === 1'b1) begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
    end
    do tick(n); while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, BRESP});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    @(posedge REF_CLK);
    ARADDR <= {24'h0, a};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do tick(n); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do tick(n); while (RVALID !== 1'b1);
    RREADY <= 1'b0;
    chk("rdata", ed, RDATA);
    chk("rresp", {30'h0, er}, {30'h0, RRESP});
  endtask

  task automatic wait_rise(input logic inv);
    int n = 0;
    logic p = 1'b1;
    forever begin
      tick(n);
      if (!p && (CLK_OUT ^ inv) === 1'b1)
        break;
      p = CLK_OUT ^ inv;
    end
  endtask

  // first rise skipped: the period it opens may still carry the old setting
  task automatic meas(input logic inv, input int eh, input int el, input string s);
    int n = 0;
    int h = 0;
    int l = 0;
    wait_rise(inv);
    wait_rise(inv);
    while ((CLK_OUT ^ inv) === 1'b1) begin
      tick(n);
      h++;
    end
    while ((CLK_OUT ^ inv) === 1'b0) begin
      tick(n);
      l++;
    end
    chk({s, " high"}, eh, h);
    chk({s, " low"}, el, l);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rd(`PD_CFG_ADDR, 32'h0, `PD_RESP_OKAY);
    wr(`PD_CFG_ADDR, 32'h5a123456, `PD_RESP_OKAY);
    rd(`PD_CFG_ADDR, 32'h00123456, `PD_RESP_OKAY);
    wr(`PD_STATUS_ADDR, 32'h0, `PD_RESP_SLVERR);
    wr(8'h10, 32'hff, `PD_RESP_SLVERR);
    rd(8'h10, 32'h0, `PD_RESP_SLVERR);
    rd(`PD_CFG_ADDR, 32'h00123456, `PD_RESP_OKAY);
    WSTRB <= 4'h2;
    wr(`PD_CFG_ADDR, 32'h00ffee00, `PD_RESP_OKAY);
    rd(`PD_CFG_ADDR, 32'h0012ee56, `PD_RESP_OKAY);
    WSTRB <= 4'hf;
  endtask

  // ratios kept far below 0xefffff
  task automatic t_norm;
    int r[4] = '{4, 5, 1, 18};
    for (int k = 0; k < 4; k++) begin
      wr(`PD_CFG_ADDR, r[k], `PD_RESP_OKAY);
      meas(1'b0, (r[k] == 1) ? 1 : (r[k] + 1) / 2, (r[k] == 1) ? 1 : r[k] / 2, "norm");
    end
  endtask

  // selector never names this divider itself
  task automatic t_frame;
    int per[3] = '{6, 4, 8};
    for (int k = 0; k < 12; k++) begin
      wr(`PD_CFG_ADDR, {8'h0, 4'hf, k[0], k[1], 2'(k / 4 + 1), 16'd3}, `PD_RESP_OKAY);
      meas(k[1], per[k / 4], 2 * per[k / 4], "frame");
    end
  endtask

  task automatic t_idle;
    logic [31:0] c[2] = '{32'h00f40003, 32'h00f10000};
    for (int k = 0; k < 2; k++) begin
      wr(`PD_CFG_ADDR, c[k], `PD_RESP_OKAY);
      repeat (70) @(posedge REF_CLK);
      chk("idle", {31'h0, c[k][18]}, {31'h0, CLK_OUT});
      rd(`PD_STATUS_ADDR, {28'h0, 1'b0, c[k][18], 2'h1}, `PD_RESP_OKAY);
    end
  endtask

  initial begin
    do_reset();
    t_regs();
    do_reset();
    rd(`PD_CFG_ADDR, 32'h0, `PD_RESP_OKAY);
    t_norm();
    t_frame();
    t_idle();
    tally_and_finish();
  end
endmodule // test_output_post_divider

bind output_post_divider post_div_sva u_sva (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
  .RREADY(RREADY), .REL_CLK_B(REL_CLK_B), .REL_CLK_C(REL_CLK_C), .REL_CLK_D(REL_CLK_D), .CLK_OUT(CLK_OUT));
`default_nettype wire
